// File: rtl/charge_state_defs.vh
// Function
// - Invalid supply or timer suspend forces init
// - Init: no charge current, timer zero, battery
// - Init exits only when supply valid
// - Thermistor low with valid supply forces buck-only
// - Thermistor high leaves buck-only, resumes charging
// - Buck-only: charging off, switch off unless supplement
// - Precharge while battery below precharge threshold
// - Precharge to trickle above precharge threshold
// - Overstaying precharge, trickle or fast charge leads to timer fault
// - Precharge works down to zero volts
// - Trickle exists only for lithium-ion variants
// - Trickle between thresholds, trickle current limit
// - Trickle to constant current above trickle threshold
// - Iron-phosphate skips trickle after precharge
// - Constant current limits to fast-charge current
// - Constant current to constant voltage at regulation
// - Constant voltage holds regulation, fast current cap
// - Low current for qualification time enters top-off
// - Top-off only from constant voltage, holds regulation
// - System load has priority over charging
// - Hot die reduces fast-charge current target
// - Top-off time to done; restart margin returns
// - Timer fault: charger off, status released
`ifndef CHARGE_STATE_DEFS_VH
`define CHARGE_STATE_DEFS_VH

`define ST_INIT 4'h0
`define ST_BUCK 4'h1
`define ST_PRECHG 4'h2
`define ST_TRICKLE 4'h3
`define ST_FAST_CC 4'h4
`define ST_FAST_CV 4'h5
`define ST_TOP_OFF 4'h6
`define ST_DONE 4'h7
`define ST_TIMER_FAULT 4'h8
`define ST_THERMAL_SHDN 4'h9

`define CURSEL_NONE 3'h0
`define CURSEL_PRECHG 3'h1
`define CURSEL_TRICKLE 3'h2
`define CURSEL_FAST 3'h3
`define CURSEL_FAST_REDUCED 3'h4
`define CURSEL_TOP_OFF 3'h5

// AXI4-Lite register byte offsets
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_PQ_TIME 8'h08
`define REG_FC_TIME 8'h0c
`define REG_TERM_TIME 8'h10
`define REG_TO_TIME 8'h14

`define CTRL_SUSPEND_BIT 0
`define CTRL_LFP_BIT 1

// Default timer counts in cycles, shortened by software or parameter
`define PQ_TIME_DEFAULT 32'h0001_0000
`define FC_TIME_DEFAULT 32'h0010_0000
`define TERM_TIME_DEFAULT 32'h0000_1000
`define TO_TIME_DEFAULT 32'h0001_0000

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// File: rtl/battery_charge_state_controller.v
`include "charge_state_defs.vh"

module battery_charge_state_controller #(
  parameter [31:0] PQ_TIME = `PQ_TIME_DEFAULT,
  parameter [31:0] FC_TIME = `FC_TIME_DEFAULT,
  parameter [31:0] TERM_TIME = `TERM_TIME_DEFAULT,
  parameter [31:0] TO_TIME = `TO_TIME_DEFAULT
) (
  // Clock, reset, enable
  input wire SYS_CLK,
  input wire RESET,
  input wire CLK_EN,
  // Analogue comparator results
  input wire SUPPLY_VALID,
  input wire THERMISTOR_ABOVE_EN,
  input wire BATT_ABOVE_PRECHG,
  input wire BATT_ABOVE_TRICKLE,
  input wire BATT_ABOVE_REG,
  input wire BATT_BELOW_RESTART,
  input wire CURRENT_BELOW_TOP_OFF,
  input wire DIE_OVER_REG_TEMP,
  input wire DIE_OVER_SHDN_TEMP,
  input wire SUPPLEMENT_REQ,
  // Charger controls
  output reg [3:0] CHARGE_STATE,
  output reg [2:0] CURRENT_SELECT,
  output reg VOLTAGE_REG_EN,
  output reg BATTERY_SWITCH_ON,
  output reg SYSTEM_FROM_BATTERY,
  output reg STATUS_OUT,
  output reg STATUS_OE,
  // AXI4-Lite slave
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);

  reg [3:0] state;
  reg [3:0] next_state;
  reg [31:0] safety_timer;
  reg [31:0] term_timer;
  reg suspend;
  reg lfp_option;
  reg [31:0] pq_time;
  reg [31:0] fc_time;
  reg [31:0] term_time;
  reg [31:0] to_time;
  reg fault_latched;
  reg supply_valid_d;

  // Write channel capture, address and data may arrive in either order
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      merge_bytes = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  function timed_state;
    input [3:0] s;
    begin
      timed_state = (s == `ST_PRECHG) || (s == `ST_TRICKLE) ||
        (s == `ST_FAST_CC) || (s == `ST_FAST_CV) || (s == `ST_TOP_OFF);
    end
  endfunction

  wire timer_hold = suspend;
  wire safety_limit_pq = (safety_timer >= pq_time);
  wire safety_limit_fc = (safety_timer >= fc_time);
  wire safety_limit_to = (safety_timer >= to_time);
  wire term_done = (term_timer >= term_time);

  // No acceptance while frozen, or the master would lose a transfer
  assign S_AXI_AWREADY = CLK_EN && !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = CLK_EN && !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = CLK_EN && !S_AXI_RVALID;

  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire aw_have = aw_held || aw_take;
  wire w_have = w_held || w_take;
  wire [7:0] wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
  wire [31:0] wr_data = w_held ? w_data : S_AXI_WDATA;
  wire [3:0] wr_strb = w_held ? w_strb : S_AXI_WSTRB;
  wire wr_fire = aw_have && w_have && !S_AXI_BVALID;

  // Next-state logic; thermal shutdown outranks everything
  always @* begin
    next_state = state;
    if (DIE_OVER_SHDN_TEMP) begin
      next_state = `ST_THERMAL_SHDN;
    end else if (state == `ST_THERMAL_SHDN) begin
      next_state = `ST_INIT;
    end else if (!SUPPLY_VALID || timer_hold) begin
      next_state = `ST_INIT;
    end else if (state == `ST_TIMER_FAULT) begin
      // Held while latched; only supply removal, suspend or thermal shutdown leave the fault state
      next_state = fault_latched ? `ST_TIMER_FAULT : `ST_INIT;
    end else if (!THERMISTOR_ABOVE_EN) begin
      next_state = `ST_BUCK;
    end else begin
      case (state)
        `ST_INIT, `ST_BUCK: begin
          // Re-qualify from the battery voltage on entry
          if (!BATT_ABOVE_PRECHG) begin
            next_state = `ST_PRECHG;
          end else if (!BATT_ABOVE_TRICKLE && !lfp_option) begin
            next_state = `ST_TRICKLE;
          end else begin
            next_state = `ST_FAST_CC;
          end
        end
        `ST_PRECHG: begin
          if (safety_limit_pq) begin
            next_state = `ST_TIMER_FAULT;
          end else if (BATT_ABOVE_PRECHG) begin
            next_state = lfp_option ? `ST_FAST_CC : `ST_TRICKLE;
          end
        end
        `ST_TRICKLE: begin
          if (lfp_option) begin
            next_state = `ST_FAST_CC;
          end else if (safety_limit_pq) begin
            next_state = `ST_TIMER_FAULT;
          end else if (BATT_ABOVE_TRICKLE) begin
            next_state = `ST_FAST_CC;
          end
        end
        `ST_FAST_CC: begin
          if (safety_limit_fc) begin
            next_state = `ST_TIMER_FAULT;
          end else if (BATT_ABOVE_REG) begin
            next_state = `ST_FAST_CV;
          end
        end
        `ST_FAST_CV: begin
          if (safety_limit_fc) begin
            next_state = `ST_TIMER_FAULT;
          end else if (term_done) begin
            next_state = `ST_TOP_OFF;
          end
        end
        `ST_TOP_OFF: begin
          if (BATT_BELOW_RESTART) begin
            next_state = `ST_FAST_CC;
          end else if (safety_limit_to) begin
            next_state = `ST_DONE;
          end
        end
        `ST_DONE: begin
          if (BATT_BELOW_RESTART) begin
            next_state = `ST_FAST_CC;
          end
        end
        default: begin
          next_state = `ST_INIT;
        end
      endcase
    end
  end

  // CC and CV share one fast-charge budget, so the timer runs on
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      state <= `ST_INIT;
      safety_timer <= 32'h0000_0000;
      term_timer <= 32'h0000_0000;
      fault_latched <= 1'b0;
      supply_valid_d <= 1'b0;
    end else if (CLK_EN) begin
      state <= next_state;
      supply_valid_d <= SUPPLY_VALID;
      if (next_state == `ST_TIMER_FAULT) begin
        fault_latched <= 1'b1;
      end else if (!SUPPLY_VALID && supply_valid_d) begin
        fault_latched <= 1'b0;
      end
      if (!timed_state(next_state)) begin
        safety_timer <= 32'h0000_0000;
      end else if (next_state != state &&
          !(state == `ST_FAST_CC && next_state == `ST_FAST_CV)) begin
        safety_timer <= 32'h0000_0000;
      end else if (safety_timer != 32'hffff_ffff) begin
        safety_timer <= safety_timer + 32'h0000_0001;
      end
      if (state == `ST_FAST_CV && next_state == `ST_FAST_CV &&
          CURRENT_BELOW_TOP_OFF) begin
        term_timer <= term_timer + 32'h0000_0001;
      end else begin
        term_timer <= 32'h0000_0000;
      end
    end
  end

  // Output decode; the analogue loops apply system-load priority
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      CHARGE_STATE <= `ST_INIT;
      CURRENT_SELECT <= `CURSEL_NONE;
      VOLTAGE_REG_EN <= 1'b0;
      BATTERY_SWITCH_ON <= 1'b0;
      SYSTEM_FROM_BATTERY <= 1'b1;
      STATUS_OUT <= 1'b0;
      STATUS_OE <= 1'b0;
    end else if (CLK_EN) begin
      CHARGE_STATE <= next_state;
      CURRENT_SELECT <= `CURSEL_NONE;
      VOLTAGE_REG_EN <= 1'b0;
      BATTERY_SWITCH_ON <= 1'b0;
      SYSTEM_FROM_BATTERY <= 1'b0;
      STATUS_OUT <= 1'b0;
      STATUS_OE <= 1'b1;
      case (next_state)
        `ST_INIT: begin
          SYSTEM_FROM_BATTERY <= 1'b1;
          BATTERY_SWITCH_ON <= 1'b1;
          STATUS_OE <= 1'b0;
        end
        `ST_BUCK: begin
          BATTERY_SWITCH_ON <= SUPPLEMENT_REQ;
          STATUS_OE <= 1'b0;
        end
        `ST_PRECHG: begin
          CURRENT_SELECT <= `CURSEL_PRECHG;
          BATTERY_SWITCH_ON <= 1'b1;
        end
        `ST_TRICKLE: begin
          CURRENT_SELECT <= `CURSEL_TRICKLE;
          BATTERY_SWITCH_ON <= 1'b1;
        end
        `ST_FAST_CC, `ST_FAST_CV: begin
          CURRENT_SELECT <= DIE_OVER_REG_TEMP ? `CURSEL_FAST_REDUCED :
            `CURSEL_FAST;
          VOLTAGE_REG_EN <= (next_state == `ST_FAST_CV);
          BATTERY_SWITCH_ON <= 1'b1;
        end
        `ST_TOP_OFF: begin
          CURRENT_SELECT <= `CURSEL_TOP_OFF;
          VOLTAGE_REG_EN <= 1'b1;
          BATTERY_SWITCH_ON <= 1'b1;
        end
        `ST_DONE: begin
          STATUS_OE <= 1'b0;
        end
        `ST_TIMER_FAULT: begin
          STATUS_OE <= 1'b0;
        end
        default: begin
          STATUS_OE <= 1'b0;
        end
      endcase
    end
  end

  // AXI4-Lite write path
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `AXI_RESP_OKAY;
      suspend <= 1'b0;
      lfp_option <= 1'b0;
      pq_time <= PQ_TIME;
      fc_time <= FC_TIME;
      term_time <= TERM_TIME;
      to_time <= TO_TIME;
    end else if (CLK_EN) begin
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= `AXI_RESP_OKAY;
        case (wr_addr)
          `REG_CONTROL: begin
            if (wr_strb[0]) begin
              suspend <= wr_data[`CTRL_SUSPEND_BIT];
              lfp_option <= wr_data[`CTRL_LFP_BIT];
            end
          end
          `REG_PQ_TIME: pq_time <= merge_bytes(pq_time, wr_data, wr_strb);
          `REG_FC_TIME: fc_time <= merge_bytes(fc_time, wr_data, wr_strb);
          `REG_TERM_TIME: begin
            term_time <= merge_bytes(term_time, wr_data, wr_strb);
          end
          `REG_TO_TIME: to_time <= merge_bytes(to_time, wr_data, wr_strb);
          `REG_STATUS: S_AXI_BRESP <= `AXI_RESP_OKAY;
          default: S_AXI_BRESP <= `AXI_RESP_SLVERR;
        endcase
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= S_AXI_AWADDR;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= S_AXI_WDATA;
          w_strb <= S_AXI_WSTRB;
        end
      end
    end
  end

  // AXI4-Lite read path
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `AXI_RESP_OKAY;
    end else if (CLK_EN) begin
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `AXI_RESP_OKAY;
        case (S_AXI_ARADDR)
          `REG_CONTROL: S_AXI_RDATA <= {30'h0, lfp_option, suspend};
          `REG_STATUS: S_AXI_RDATA <= {23'h0, fault_latched, SUPPLY_VALID,
            CURRENT_SELECT, state};
          `REG_PQ_TIME: S_AXI_RDATA <= pq_time;
          `REG_FC_TIME: S_AXI_RDATA <= fc_time;
          `REG_TERM_TIME: S_AXI_RDATA <= term_time;
          `REG_TO_TIME: S_AXI_RDATA <= to_time;
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `AXI_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule // battery_charge_state_controller

// File: verification/cell_model.sv
module cell_model (
  // Battery level set by the bench
  input wire logic [1:0] lvl,
  // Comparator levels seen by the charger
  output logic above_prechg,
  output logic above_trickle,
  output logic above_reg,
  output logic below_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  // Level 0 stands for a dead pack at zero volts
  assign above_prechg = lvl >= 2'h1;
  assign above_trickle = lvl >= 2'h2;
  assign above_reg = lvl == 2'h3;
  // Restart margin sits just under regulation
  assign below_restart = lvl != 2'h3;
endmodule // cell_model

// File: verification/charge_chk.sv
`include "charge_state_defs.vh"
module charge_chk #(
  parameter [31:0] FC_TIME = 32'h0010_0000
) (
  // Clock and reset
  input wire SYS_CLK,
  input wire RESET,
  // Inputs
  input wire CLK_EN,
  input wire SUPPLY_VALID,
  input wire THERMISTOR_ABOVE_EN,
  input wire BATT_ABOVE_REG,
  input wire DIE_OVER_REG_TEMP,
  input wire DIE_OVER_SHDN_TEMP,
  input wire SUPPLEMENT_REQ,
  // Outputs
  input wire [3:0] CHARGE_STATE,
  input wire [2:0] CURRENT_SELECT,
  input wire VOLTAGE_REG_EN,
  input wire BATTERY_SWITCH_ON,
  input wire SYSTEM_FROM_BATTERY,
  input wire STATUS_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  wire on = SUPPLY_VALID && !DIE_OVER_SHDN_TEMP && CLK_EN;
  wire go = on && THERMISTOR_ABOVE_EN;
  wire [3:0] s = CHARGE_STATE;
  wire fast = s == `ST_FAST_CC || s == `ST_FAST_CV;
  reg [31:0] fc_cnt;
  // Counts the shared CC and CV budget
  always @(posedge SYS_CLK) begin
    if (RESET || !fast)
      fc_cnt <= 32'h0;
    else
      fc_cnt <= fc_cnt + 32'h1;
  end
  init_forced_a: assert property (
    CLK_EN && !SUPPLY_VALID && !DIE_OVER_SHDN_TEMP |=> s == `ST_INIT)
    else $error("init not forced");
  init_idle_a: assert property (
    s == `ST_INIT |-> CURRENT_SELECT == 3'h0 && SYSTEM_FROM_BATTERY)
    else $error("init outputs wrong");
  buck_entry_a: assert property (
    on && !THERMISTOR_ABOVE_EN |=>
    s inside {`ST_BUCK, `ST_INIT, `ST_TIMER_FAULT})
    else $error("buck not entered");
  buck_leave_a: assert property (
    go && s == `ST_BUCK |=> s != `ST_BUCK) else $error("buck not left");
  // Outputs follow inputs of the last enabled edge only
  buck_switch_a: assert property (
    s == `ST_BUCK && $past(CLK_EN) && !$past(SUPPLEMENT_REQ) |->
    !BATTERY_SWITCH_ON && CURRENT_SELECT == 3'h0)
    else $error("buck charging");
  prechg_cur_a: assert property (
    s == `ST_PRECHG |-> STATUS_OE && CURRENT_SELECT == `CURSEL_PRECHG)
    else $error("precharge current wrong");
  trickle_cur_a: assert property (
    s == `ST_TRICKLE |-> CURRENT_SELECT == `CURSEL_TRICKLE)
    else $error("trickle current wrong");
  cc_fold_a: assert property (
    s == `ST_FAST_CC && $past(CLK_EN) |-> CURRENT_SELECT ==
    ($past(DIE_OVER_REG_TEMP) ? `CURSEL_FAST_REDUCED : `CURSEL_FAST))
    else $error("fast current wrong");
  cc_to_cv_a: assert property (
    go && s == `ST_FAST_CC && BATT_ABOVE_REG |=>
    s inside {`ST_FAST_CV, `ST_INIT, `ST_TIMER_FAULT}) else $error("no CV");
  volt_reg_a: assert property (
    s inside {`ST_FAST_CV, `ST_TOP_OFF} |-> VOLTAGE_REG_EN)
    else $error("regulation off");
  topoff_src_a: assert property (
    s == `ST_TOP_OFF && $past(s) != `ST_TOP_OFF |-> $past(s) == `ST_FAST_CV)
    else $error("top-off entered wrongly");
  fault_off_a: assert property (
    s == `ST_TIMER_FAULT |-> !STATUS_OE && CURRENT_SELECT == 3'h0)
    else $error("fault not off");
  fc_limit_a: assert property (fc_cnt <= FC_TIME + 32'h1)
    else $error("fast charge overstayed");
  cover property (s == `ST_DONE);
  cover property (s == `ST_TIMER_FAULT);
  cover property (s == `ST_BUCK && SUPPLEMENT_REQ);
  cover property (s == `ST_THERMAL_SHDN);
endmodule // charge_chk

bind battery_charge_state_controller charge_chk #(.FC_TIME(FC_TIME)) u_chk (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .CLK_EN(CLK_EN),
  .SUPPLY_VALID(SUPPLY_VALID), .THERMISTOR_ABOVE_EN(THERMISTOR_ABOVE_EN),
  .BATT_ABOVE_REG(BATT_ABOVE_REG), .DIE_OVER_REG_TEMP(DIE_OVER_REG_TEMP),
  .DIE_OVER_SHDN_TEMP(DIE_OVER_SHDN_TEMP), .SUPPLEMENT_REQ(SUPPLEMENT_REQ),
  .CHARGE_STATE(CHARGE_STATE), .CURRENT_SELECT(CURRENT_SELECT),
  .VOLTAGE_REG_EN(VOLTAGE_REG_EN), .BATTERY_SWITCH_ON(BATTERY_SWITCH_ON),
  .SYSTEM_FROM_BATTERY(SYSTEM_FROM_BATTERY), .STATUS_OE(STATUS_OE)
);

// File: verification/battery_charge_state_controller_test.sv
`include "charge_state_defs.vh"
module battery_charge_state_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] PQ = 32'd20;
  localparam [31:0] TO = 32'd10;
  logic clk, rst, sv, thermistor_control_input, lowi, hot, sup, en, shdn;
  logic [1:0] lvl;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rd;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [1:0] rs;
  wire ap, at, ar, br, awready, wready, bvalid, arready, rvalid;
  wire vr, bsw, sfb, soe, so;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] st;
  wire [2:0] cs;
  int error_cnt = 0;
  int checks_done = 0;
  int n;

  cell_model i_cell (.lvl(lvl), .above_prechg(ap), .above_trickle(at),
    .above_reg(ar), .below_restart(br));
  battery_charge_state_controller #(.PQ_TIME(PQ), .FC_TIME(32'd40),
    .TERM_TIME(32'd5), .TO_TIME(TO)) i_dut (
    .SYS_CLK(clk), .RESET(rst), .CLK_EN(en), .SUPPLY_VALID(sv),
    .THERMISTOR_ABOVE_EN(thermistor_control_input), .BATT_ABOVE_PRECHG(ap),
    .BATT_ABOVE_TRICKLE(at), .BATT_ABOVE_REG(ar), .BATT_BELOW_RESTART(br),
    .CURRENT_BELOW_TOP_OFF(lowi), .DIE_OVER_REG_TEMP(hot),
    .DIE_OVER_SHDN_TEMP(shdn), .SUPPLEMENT_REQ(sup), .CHARGE_STATE(st),
    .CURRENT_SELECT(cs), .VOLTAGE_REG_EN(vr), .BATTERY_SWITCH_ON(bsw),
    .SYSTEM_FROM_BATTERY(sfb), .STATUS_OUT(so), .STATUS_OE(soe),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task end_of_test;
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task hang;
    chk("bus response", 32'h1, 32'h0);
    end_of_test;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    rs = bresp;
    if (i == 20) hang;
  endtask

  task rdr(input logic [7:0] a);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    if (i == 20) hang;
  endtask

  // Waits a bounded time for a state and compares it
  task ws(input logic [3:0] s, output int c);
    for (c = 0; c < 200; c++) begin
      @(posedge clk);
      if (st === s) break;
    end
    chk("state", {28'h0, s}, {28'h0, st});
    if (c == 200) end_of_test;
  endtask

  task tick2;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {rst, thermistor_control_input, en} = 3'h7;
    {sv, lowi, hot, sup, shdn} = 5'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {lvl, awaddr, araddr, wdata} = 50'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdr(`REG_TERM_TIME);
    chk("term time", 32'd5, rd);
    wr(`REG_TERM_TIME, 32'd6);
    chk("write resp", {30'h0, `AXI_RESP_OKAY}, {30'h0, rs});
    wr(8'h20, 32'h0);
    chk("bad wr resp", {30'h0, `AXI_RESP_SLVERR}, {30'h0, rs});
    rdr(`REG_TERM_TIME);
    chk("term time", 32'd6, rd);
    rdr(8'h20);
    chk("unmapped resp", {30'h0, `AXI_RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0, rd);
    rdr(`REG_STATUS);
    chk("idle status", 32'h0, {23'h0, rd[8:0]});
    $display("Test registers done");
    // A frozen block must not leave init although the supply is valid
    en <= 1'b0;
    sv <= 1'b1;
    tick2;
    chk("frozen", `ST_INIT, st);
    en <= 1'b1;
    ws(`ST_PRECHG, n);
    lvl <= 2'h1;
    ws(`ST_TRICKLE, n);
    lvl <= 2'h2;
    hot <= 1'b1;
    ws(`ST_FAST_CC, n);
    chk("hot current", `CURSEL_FAST_REDUCED, cs);
    hot <= 1'b0;
    tick2;
    chk("fast current", `CURSEL_FAST, cs);
    lvl <= 2'h3;
    ws(`ST_FAST_CV, n);
    chk("regulate", 32'h1, vr);
    lowi <= 1'b1;
    ws(`ST_TOP_OFF, n);
    chk("term wait", 32'h1, n >= 6 && n <= 8);
    ws(`ST_DONE, n);
    chk("top-off wait", 32'h1, n >= TO - 2 && n <= TO + 2);
    lvl <= 2'h2;
    lowi <= 1'b0;
    ws(`ST_FAST_CC, n);
    $display("Test charge cycle done");
    rdr(`REG_STATUS);
    chk("supply ok", 32'h1, rd[7]);
    thermistor_control_input <= 1'b0;
    ws(`ST_BUCK, n);
    chk("switch off", 32'h0, bsw);
    sup <= 1'b1;
    tick2;
    chk("switch on", 32'h1, bsw);
    sup <= 1'b0;
    thermistor_control_input <= 1'b1;
    ws(`ST_FAST_CC, n);
    wr(`REG_CONTROL, 32'h1);
    ws(`ST_INIT, n);
    chk("from battery", 32'h1, sfb);
    lvl <= 2'h0;
    wr(`REG_CONTROL, 32'h2);
    ws(`ST_PRECHG, n);
    lvl <= 2'h1;
    tick2;
    chk("skip trickle", `ST_FAST_CC, st);
    sv <= 1'b0;
    ws(`ST_INIT, n);
    $display("Test buck and suspend done");
    wr(`REG_CONTROL, 32'h0);
    lvl <= 2'h0;
    sv <= 1'b1;
    ws(`ST_PRECHG, n);
    ws(`ST_TIMER_FAULT, n);
    chk("fault time", 32'h1, n >= PQ - 2 && n <= PQ + 2);
    chk("status released", 32'h0, soe);
    chk("status level", 32'h0, so);
    rdr(`REG_STATUS);
    chk("fault latch", 32'h1, rd[8]);
    sv <= 1'b0;
    tick2;
    sv <= 1'b1;
    ws(`ST_PRECHG, n);
    $display("Test timer fault done");
    shdn <= 1'b1;
    ws(`ST_THERMAL_SHDN, n);
    chk("shutdown current", `CURSEL_NONE, cs);
    chk("shutdown status", 32'h0, soe);
    sv <= 1'b0;
    tick2;
    chk("shutdown kept", `ST_THERMAL_SHDN, st);
    shdn <= 1'b0;
    ws(`ST_INIT, n);
    $display("Test shutdown done");
    end_of_test;
  end
endmodule // battery_charge_state_controller_test
